// File: include/spi_wm_consts.vh
// Contract
// - Receive watermark event when enabled and rx threshold <= rx fill count.
// - Transmit watermark event when enabled and tx threshold equals tx fill count.
// - No watermark match when threshold exceeds configured queue depth.
// - Threshold bits 2/3/4 exist only for depth 8/16/32 or more.
// - Watermark control bits 14 and 6 read as zero.
// - On underrun with fill enable set, shift out the fill word instead.
// - Lengths 16..9 use fill bits 15:0; lengths 8..2 use bits 7:0.
// - Lengths 32..25 use bits 31:0; lengths 24..17 use bits 23:0.
// - Serial clock is bus clock divided by 2*(divisor+1).
// - One buffer address: writes go to transmit, reads come from receive.
// - Six-bit transmit and receive fill counts of occupied elements.
`ifndef SPI_WM_CONSTS_VH
`define SPI_WM_CONSTS_VH
`define A_WM_CTRL 4'h0
`define A_FILL_LO 4'h1
`define A_FILL_HI 4'h2
`define A_DIVISOR 4'h3
`define A_CONFIG 4'h4
`define A_STATUS 4'h5
`define A_IRQ_STAT 4'h6
`define A_IRQ_MASK 4'h7
`define A_BUFFER 4'h8
`define A_FILLCNT 4'h9
`define RX_EN_BIT 15
`define TX_EN_BIT 7
`define CFG_ON_BIT 0
`define CFG_FILL_EN_BIT 1
`define CFG_ENH_BIT 2
`define CFG_WLEN_LSB 8
`define CTRL_IMPL_MASK 16'hBFBF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DIV_W 13
`define CNT_W 6
`endif

// File: rtl/sck_divider.v
`timescale 1ns/10ps
`include "spi_wm_consts.vh"
module sck_divider
(
    input wire clk,
    input wire rst,
    input wire run,
    input wire [`DIV_W-1:0] divisor,
    output reg sck
);
    reg [`DIV_W-1:0] cnt_reg;
    // Half period is divisor+1 bus clocks, full period 2*(divisor+1)
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= {`DIV_W{1'b0}};
            sck <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg <= {`DIV_W{1'b0}};
            sck <= 1'b0;
        end
        else if (cnt_reg >= divisor)
        begin
            cnt_reg <= {`DIV_W{1'b0}};
            sck <= ~sck;
        end
        else
            cnt_reg <= cnt_reg + {{(`DIV_W-1){1'b0}}, 1'b1};
    end
endmodule

// File: rtl/level_watch.v
`timescale 1ns/10ps
`include "spi_wm_consts.vh"
module level_watch
#(
    parameter DEPTH = 8
)
(
    input wire [`CNT_W-1:0] threshold,
    input wire [`CNT_W-1:0] fill,
    input wire enable,
    input wire exact,
    output wire hit
);
    // Threshold beyond the queue depth can never match
    wire in_range = ({26'h0, threshold} <= DEPTH);
    wire cmp = exact ? (threshold == fill) : (threshold <= fill);
    assign hit = enable && in_range && cmp;
endmodule

// File: rtl/spi_watermark_underrun_fill.v
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "spi_wm_consts.vh"
module spi_watermark_underrun_fill
#(
    parameter QUEUE_DEPTH = 8
)
(
    input wire core_clk,
    input wire rst,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`CNT_W-1:0] tx_fill_count,
    input wire [`CNT_W-1:0] rx_fill_count,
    input wire tx_underrun,
    input wire [31:0] tx_queue_word,
    input wire [31:0] rx_holding_reg,
    output reg [31:0] tx_holding_reg,
    output reg tx_holding_wr,
    output reg rx_holding_rd,
    output reg [31:0] tx_shift_word,
    output reg [4:0] word_length_select,
    output reg module_on,
    output reg enhanced_mode,
    output reg sck,
    output reg irq
);
    // Threshold bits present for the configured depth
    localparam [5:0] THR_MASK = (QUEUE_DEPTH >= 32) ? 6'h3F : (QUEUE_DEPTH >= 16) ? 6'h2F :
        (QUEUE_DEPTH >= 8) ? 6'h27 : 6'h23;

    reg [15:0] wm_ctrl_reg;
    reg [31:0] fill_word_reg;
    reg [`DIV_W-1:0] divisor_reg;
    reg fill_en_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg rx_hit_d_reg;
    reg tx_hit_d_reg;
    reg aw_held_reg;
    reg w_held_reg;
    reg [3:0] aw_idx_reg;
    reg [31:0] wdata_reg;
    wire rx_hit;
    wire tx_hit;
    wire sck_raw;

    function [3:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[5:2];
        end
    endfunction

    function [5:0] thr_field;
        input [5:0] v;
        begin
            thr_field = v & THR_MASK;
        end
    endfunction

    level_watch #(.DEPTH(QUEUE_DEPTH)) rx_watch
    (
        .threshold(wm_ctrl_reg[13:8]),
        .fill(rx_fill_count),
        .enable(wm_ctrl_reg[`RX_EN_BIT]),
        .exact(1'b0),
        .hit(rx_hit)
    );

    level_watch #(.DEPTH(QUEUE_DEPTH)) tx_watch
    (
        .threshold(wm_ctrl_reg[5:0]),
        .fill(tx_fill_count),
        .enable(wm_ctrl_reg[`TX_EN_BIT]),
        .exact(1'b1),
        .hit(tx_hit)
    );

    sck_divider clk_gen
    (
        .clk(core_clk),
        .rst(rst),
        .run(module_on),
        .divisor(divisor_reg),
        .sck(sck_raw)
    );

    // Fill word lanes chosen by word length; value is length-1
    reg [31:0] fill_sel;
    always @*
    begin
        fill_sel = 32'h0;
        if (word_length_select == 5'h0 || word_length_select >= 5'h18)
            fill_sel = fill_word_reg;
        else if (word_length_select >= 5'h10)
            fill_sel = {8'h0, fill_word_reg[23:0]};
        else if (word_length_select >= 5'h08)
            fill_sel = {16'h0, fill_word_reg[15:0]};
        else
            fill_sel = {24'h0, fill_word_reg[7:0]};
    end

    // Unmapped word indexes answer with a slave error on both channels
    function [1:0] resp_for;
        input [3:0] idx;
        begin
            if (idx <= `A_FILLCNT)
                resp_for = `RESP_OKAY;
            else
                resp_for = `RESP_SLVERR;
        end
    endfunction

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    // Both halves present, either held from an earlier edge or taken at this one
    wire do_write = (aw_held_reg || aw_take) && (w_held_reg || w_take);
    wire [3:0] wr_idx = aw_held_reg ? aw_idx_reg : word_index(s_axi_awaddr);
    wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [3:0] rd_idx = word_index(s_axi_araddr);
    wire stat_read = do_read && rd_idx == `A_IRQ_STAT;

    // Write address and data channels; each ready is offered for one cycle only
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= 4'h0;
            wdata_reg <= 32'h0;
        end
        else
        begin
            // No new handshake on a channel while its own half is held or a response is pending
            s_axi_awready <= !aw_held_reg && s_axi_awvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held_reg && s_axi_wvalid && !s_axi_wready && !s_axi_bvalid;
            if (aw_take && !do_write)
            begin
                aw_held_reg <= 1'b1;
                aw_idx_reg <= word_index(s_axi_awaddr);
            end
            if (w_take && !do_write)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= resp_for(wr_idx);
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register file; read-only and unmapped words ignore writes
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wm_ctrl_reg <= 16'h0;
            fill_word_reg <= 32'h0;
            divisor_reg <= {`DIV_W{1'b0}};
            fill_en_reg <= 1'b0;
            word_length_select <= 5'h0;
            module_on <= 1'b0;
            enhanced_mode <= 1'b0;
            irq_mask_reg <= 2'h0;
            tx_holding_reg <= 32'h0;
            tx_holding_wr <= 1'b0;
        end
        else
        begin
            tx_holding_wr <= 1'b0;
            if (do_write)
            begin
                case (wr_idx)
                    // Absent threshold bits are dropped here, so reads show what matches
                    `A_WM_CTRL:
                        wm_ctrl_reg <= {wr_data[15], 1'b0, thr_field(wr_data[13:8]),
                            wr_data[7], 1'b0, thr_field(wr_data[5:0])};
                    `A_FILL_LO: fill_word_reg[15:0] <= wr_data[15:0];
                    `A_FILL_HI: fill_word_reg[31:16] <= wr_data[15:0];
                    `A_DIVISOR: divisor_reg <= wr_data[`DIV_W-1:0];
                    `A_CONFIG:
                    begin
                        module_on <= wr_data[`CFG_ON_BIT];
                        fill_en_reg <= wr_data[`CFG_FILL_EN_BIT];
                        enhanced_mode <= wr_data[`CFG_ENH_BIT];
                        word_length_select <= wr_data[`CFG_WLEN_LSB+4:`CFG_WLEN_LSB];
                    end
                    `A_IRQ_MASK: irq_mask_reg <= wr_data[1:0];
                    `A_BUFFER:
                    begin
                        tx_holding_reg <= wr_data;
                        tx_holding_wr <= 1'b1;
                    end
                    default: tx_holding_wr <= 1'b0;
                endcase
            end
        end
    end

    // Read channel; arready stays low while an answer waits, so one read at a time
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0;
            rx_holding_rd <= 1'b0;
        end
        else
        begin
            rx_holding_rd <= 1'b0;
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= resp_for(rd_idx);
                // Data is captured with rvalid and stands until rready
                case (rd_idx)
                    `A_WM_CTRL: s_axi_rdata <= {16'h0, wm_ctrl_reg & `CTRL_IMPL_MASK};
                    `A_FILL_LO: s_axi_rdata <= {16'h0, fill_word_reg[15:0]};
                    `A_FILL_HI: s_axi_rdata <= {16'h0, fill_word_reg[31:16]};
                    `A_DIVISOR: s_axi_rdata <= {19'h0, divisor_reg};
                    `A_CONFIG: s_axi_rdata <= {19'h0, word_length_select, 5'h0,
                        enhanced_mode, fill_en_reg, module_on};
                    `A_STATUS: s_axi_rdata <= {29'h0, tx_underrun, tx_hit, rx_hit};
                    `A_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_reg};
                    `A_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_reg};
                    `A_BUFFER:
                    begin
                        s_axi_rdata <= rx_holding_reg;
                        rx_holding_rd <= 1'b1;
                    end
                    `A_FILLCNT: s_axi_rdata <= {18'h0, rx_fill_count, 2'h0, tx_fill_count};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Events are rising edges of the match; set wins over read-clear
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_hit_d_reg <= 1'b0;
            tx_hit_d_reg <= 1'b0;
            irq_stat_reg <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            rx_hit_d_reg <= rx_hit;
            tx_hit_d_reg <= tx_hit;
            irq_stat_reg <= (stat_read ? 2'h0 : irq_stat_reg) |
                {tx_hit && !tx_hit_d_reg, rx_hit && !rx_hit_d_reg};
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Re-timed so these outputs leave flip-flops; costs one cycle of lag
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sck <= 1'b0;
            tx_shift_word <= 32'h0;
        end
        else
        begin
            sck <= sck_raw;
            tx_shift_word <= (tx_underrun && fill_en_reg) ? fill_sel : tx_queue_word;
        end
    end
endmodule

// File: test/spi_wm_checker.sv
`timescale 1ns/10ps
module spi_wm_checker
#(
    parameter QUEUE_DEPTH = 8
)
(
    input wire core_clk,
    input wire rst,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_underrun,
    input wire [31:0] tx_queue_word,
    input wire tx_holding_wr,
    input wire rx_holding_rd,
    input wire [31:0] tx_shift_word,
    input wire module_on,
    input wire sck
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Two cycles of slack cover the extra divider lag after switch-off
    sck_idle_a: assert property (!module_on && !$past(module_on) && !$past(module_on, 2) |-> !sck)
        else $error("serial clock runs while module is off");
    sck_run_a: assert property ($rose(sck) |-> $past(module_on, 2))
        else $error("serial clock rose without module on");
    fill_pass_a: assert property (!tx_underrun |=> tx_shift_word == $past(tx_queue_word))
        else $error("queued word not passed without underrun");
    wr_pulse_a: assert property (tx_holding_wr |=> !tx_holding_wr)
        else $error("transmit write strobe longer than one cycle");
    rd_pulse_a: assert property (rx_holding_rd |-> $rose(s_axi_rvalid))
        else $error("receive read strobe without read answer");
    wr_resp_a: assert property (tx_holding_wr |-> ##[0:3] s_axi_bvalid)
        else $error("buffer write without response");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed early");
    ar_gap_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
endmodule

// File: test/spi_peer_model.sv
`timescale 1ns/10ps
module spi_peer_model
(
    input wire core_clk,
    input wire rst,
    input wire tx_holding_wr,
    input wire [31:0] tx_holding_reg,
    input wire [5:0] tx_req,
    input wire [5:0] rx_req,
    output reg [5:0] tx_fill_count,
    output reg [5:0] rx_fill_count,
    output reg [31:0] tx_queue_word,
    output reg [31:0] rx_holding_reg
);
    // Peer replies with the inverse of the word sent, so a stale echo is caught
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_fill_count <= 6'h00;
            rx_fill_count <= 6'h00;
            tx_queue_word <= 32'h00000000;
            rx_holding_reg <= 32'h00000000;
        end
        else
        begin
            tx_fill_count <= tx_req;
            rx_fill_count <= rx_req;
            if (tx_holding_wr)
            begin
                tx_queue_word <= tx_holding_reg;
                rx_holding_reg <= ~tx_holding_reg;
            end
        end
    end
endmodule

// File: test/test_spi_watermark_underrun_fill.sv
`timescale 1ns/10ps
`include "spi_wm_consts.vh"
module test_spi_watermark_underrun_fill;
    reg core_clk = 1'h0;
    reg rst = 1'h1;
    reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tx_underrun = 1'h0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [5:0] tx_req = 6'h00, rx_req = 6'h00;
    wire [5:0] tx_fill_count, rx_fill_count;
    wire [31:0] tx_queue_word, rx_holding_reg, tx_holding_reg, tx_shift_word, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [4:0] word_length_select;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire tx_holding_wr, rx_holding_rd, module_on, enhanced_mode, sck, irq;
    integer err_total = 0, num_checks = 0, cyc = 0, i, a, b;
    integer lens [0:7] = '{32, 25, 24, 17, 16, 9, 8, 2};
    reg ps, got;
    spi_watermark_underrun_fill #(.QUEUE_DEPTH(8)) uut (.*);
    spi_peer_model peer (.*);
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            summarize;
        end
    end
    function [31:0] ad(input [3:0] x);
        ad = {26'h0, x, 2'h0};
    endfunction
    task chk(input [31:0] s, input [31:0] e);
        num_checks = num_checks + 1;
        if (s !== e)
        begin
            err_total = err_total + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input [31:0] ad_, input [31:0] d, input [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= ad_;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        got = 1'h0;
        while (!got)
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
            begin
                got = 1'h1;
                s_axi_bready <= 1'h0;
                chk({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
    endtask
    task rd(input [31:0] ad_, input [31:0] e, input [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= ad_;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        got = 1'h0;
        while (!got)
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
            begin
                got = 1'h1;
                s_axi_rready <= 1'h0;
                chk(s_axi_rdata, e);
                chk({30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
    endtask
    // Counts drop to zero first so each case sees a fresh rising match
    task ev(input [1:0] m, input [15:0] c, input [5:0] t, input [5:0] r, input [1:0] e);
        @(posedge core_clk);
        tx_req <= 6'h00;
        rx_req <= 6'h00;
        wr(ad(`A_IRQ_MASK), {30'h0, m}, `RESP_OKAY);
        wr(ad(`A_WM_CTRL), {16'h0, c}, `RESP_OKAY);
        @(posedge core_clk);
        tx_req <= t;
        rx_req <= r;
        repeat (5) @(posedge core_clk);
        chk({31'h0, irq}, {31'h0, |(e & m)});
        rd(ad(`A_STATUS), {30'h0, e}, `RESP_OKAY);
        rd(ad(`A_FILLCNT), {18'h0, r, 2'h0, t}, `RESP_OKAY);
        rd(ad(`A_IRQ_STAT), {30'h0, e}, `RESP_OKAY);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'h0;
        rd(ad(`A_WM_CTRL), 32'h0, `RESP_OKAY);
        rd(ad(`A_FILL_HI), 32'h0, `RESP_OKAY);
        wr(ad(`A_WM_CTRL), 32'hFFFFFFFF, `RESP_OKAY);
        rd(ad(`A_WM_CTRL), 32'h0000A7A7, `RESP_OKAY);
        wr(32'h0000003C, 32'h1, `RESP_SLVERR);
        rd(32'h0000003C, 32'h0, `RESP_SLVERR);
        $display("test registers done");
        ev(2'h3, 16'h8400, 6'h00, 6'h03, 2'h0);
        ev(2'h3, 16'h8400, 6'h00, 6'h04, 2'h1);
        ev(2'h0, 16'h8400, 6'h00, 6'h09, 2'h1);
        ev(2'h3, 16'h0400, 6'h00, 6'h09, 2'h0);
        ev(2'h3, 16'h0085, 6'h06, 6'h00, 2'h0);
        ev(2'h3, 16'h0085, 6'h05, 6'h00, 2'h2);
        ev(2'h3, 16'h0005, 6'h05, 6'h00, 2'h0);
        ev(2'h3, 16'hA000, 6'h00, 6'h3F, 2'h0);
        ev(2'h3, 16'h00A0, 6'h20, 6'h00, 2'h0);
        $display("test watermark done");
        wr(ad(`A_BUFFER), 32'h13579BDF, `RESP_OKAY);
        chk(tx_holding_reg, 32'h13579BDF);
        rd(ad(`A_BUFFER), 32'hECA86420, `RESP_OKAY);
        $display("test buffer done");
        wr(ad(`A_FILL_LO), 32'h0000A5C3, `RESP_OKAY);
        wr(ad(`A_FILL_HI), 32'h00005A3C, `RESP_OKAY);
        rd(ad(`A_FILL_LO), 32'h0000A5C3, `RESP_OKAY);
        for (i = 0; i < 8; i = i + 1)
        begin
            a = lens[i] > 24 ? 32'hFFFFFFFF : lens[i] > 16 ? 32'hFFFFFF
                : lens[i] > 8 ? 32'hFFFF : 32'hFF;
            wr(ad(`A_CONFIG), 32'h2 | (((lens[i] - 1) & 31) << 8), `RESP_OKAY);
            tx_underrun <= 1'h1;
            repeat (3) @(posedge core_clk);
            chk({27'h0, word_length_select}, (lens[i] - 1) & 31);
            chk(tx_shift_word, 32'h5A3CA5C3 & a);
            wr(ad(`A_CONFIG), ((lens[i] - 1) & 31) << 8, `RESP_OKAY);
            repeat (3) @(posedge core_clk);
            chk(tx_shift_word, 32'h13579BDF);
            tx_underrun <= 1'h0;
        end
        $display("test underrun done");
        wr(ad(`A_DIVISOR), 32'h3, `RESP_OKAY);
        rd(ad(`A_DIVISOR), 32'h3, `RESP_OKAY);
        wr(ad(`A_CONFIG), 32'h5, `RESP_OKAY);
        chk({31'h0, enhanced_mode}, 32'h1);
        a = 0;
        b = 0;
        ps = sck;
        for (i = 0; i < 40; i = i + 1)
        begin
            @(posedge core_clk);
            if (sck && !ps)
            begin
                a = b;
                b = i;
            end
            ps = sck;
        end
        chk({31'h0, module_on}, 32'h1);
        chk(b - a, 2 * (3 + 1));
        wr(ad(`A_CONFIG), 32'h0, `RESP_OKAY);
        repeat (4) @(posedge core_clk);
        chk({31'h0, sck}, 32'h0);
        $display("test clock done");
        summarize;
    end
endmodule

bind spi_watermark_underrun_fill spi_wm_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_i (.*);
